//--- rtl/spi_queue_periodic.sv
// SPI queue windows, chip select and periodic transfer engine
`timescale 1ns/1ps
module spi_queue_periodic
	import spi_pq_pkg::*;
#(
	parameter int        DEPTH          = 3,
	parameter int        SEL_COUNT      = 1,
	parameter bit        SEL_PRESENT    = 1'b1,
	parameter bit        AUTO_SEL_AVAIL = 1'b1,
	parameter bit        PERIODIC_AVAIL = 1'b1,
	parameter int        PERIOD_BITS    = 32
)(
	input  wire logic                 i_clk,
	input  wire logic                 i_resetn,
	input  wire logic                 i_link_clk,
	input  wire logic                 i_psel,
	input  wire logic                 i_penable,
	input  wire logic                 i_pwrite,
	input  wire logic [7:0]           i_paddr,
	input  wire logic [31:0]          i_pwdata,
	output logic [31:0]               o_prdata,
	output logic                      o_pready,
	output logic                      o_pslverr,
	input  wire logic                 i_periodic_trigger_pin,
	output logic                      o_periodic_trigger,
	output logic [SEL_COUNT-1:0]      o_select,
	input  wire logic                 i_miso,
	output logic                      o_mosi,
	output logic                      o_frame
);
	localparam int CW = $clog2(DEPTH + 1);
	localparam int PW = $clog2(DEPTH);
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
	localparam logic [31:0] PER_MASK = (PERIOD_BITS >= 32) ? 32'hFFFF_FFFF :
		32'((64'h1 << PERIOD_BITS) - 64'h1);

	// Ring pointer step; used by both queues
	function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	// Received word placement by size and order [RL7]
	function automatic logic [31:0] place(input logic [31:0] raw, input logic [3:0] len,
		input logic rev);
		if (len == 4'h0)
			return raw;
		else if (rev)
			return raw << RX_HALF;
		else
			return raw >> RX_HALF;
	endfunction

	logic [31:0] tx_mem [DEPTH];
	logic [31:0] rx_mem [DEPTH];
	logic [PW-1:0] tx_wr_reg, tx_rd_reg, rx_wr_reg, rx_rd_reg;
	logic [CW-1:0] tx_cnt_reg, rx_cnt_reg;
	logic [6:0]    cfg_reg;
	logic [31:0]   cs_reg, acs_reg, per_reg, pcnt_reg;
	logic [5:0]    pcfg_reg;
	logic          final_armed_reg, final_event_reg, char_seen_reg;
	logic          link_busy_reg, burst_reg, stop_pend_reg, drained_reg;
	logic          start_tgl_reg;
	logic [31:0]   tx_hold_reg;
	logic [5:0]    nbits_reg;
	logic          hold_rev_reg;
	logic          d1_reg, d2_reg, d3_reg;
	logic          t1_reg, t2_reg;
	logic          done_pulse, xfer_busy, start_word, periodic_mode;
	logic          wr_acc, rd_acc, rd_setup, rx_pop, tx_push;
	logic          at_zero, gate_ok, skip_burst, fire, stop_done;
	logic          final_set, map_hit;
	logic [31:0]   rx_raw, rx_word;
	logic [CW:0]   occupancy;
	logic          done_tgl_link;

	// Link-side shifter on its own clock
	spi_link_shifter u_shift (
		.i_link_clk  (i_link_clk),
		.i_resetn    (i_resetn),
		.i_start_tgl (start_tgl_reg),
		.i_tx_word   (tx_hold_reg),
		.i_nbits     (nbits_reg),
		.i_msb_first (hold_rev_reg),
		.i_miso      (i_miso),
		.o_done_tgl  (done_tgl_link),
		.o_rx_raw    (rx_raw),
		.o_mosi      (o_mosi),
		.o_frame     (o_frame)
	);

	// Done toggle comes back through two flops; raw word is stable by then
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			d1_reg <= 1'b0;
			d2_reg <= 1'b0;
			d3_reg <= 1'b0;
			t1_reg <= 1'b0;
			t2_reg <= 1'b0;
		end else begin
			d1_reg <= done_tgl_link;
			d2_reg <= d1_reg;
			d3_reg <= d2_reg;
			t1_reg <= i_periodic_trigger_pin;
			t2_reg <= t1_reg;
		end
	end
	assign done_pulse = d2_reg ^ d3_reg;

	// Bus decode; the slave never waits
	assign o_pready = 1'b1;
	assign wr_acc   = i_psel & i_penable & i_pwrite;
	assign rd_acc   = i_psel & i_penable & ~i_pwrite;
	assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
	assign rx_pop   = rd_acc & (i_paddr == OFS_RX) & (rx_cnt_reg != '0);
	assign tx_push  = wr_acc & (i_paddr == OFS_TX) & (tx_cnt_reg != DEPTH_C); // [RL4]
	assign map_hit  = (i_paddr == OFS_CFG) | (i_paddr == OFS_STAT) | (i_paddr == OFS_CMD) |
		(i_paddr == OFS_TX) | (i_paddr == OFS_RX) | (i_paddr == OFS_CS) |
		(i_paddr == OFS_ACS) | (i_paddr == OFS_PCFG) | (i_paddr == OFS_PER);
	assign o_pslverr = i_psel & i_penable & ~map_hit;

	// Word start: immediate when idle, only inside a burst in periodic mode
	assign periodic_mode = pcfg_reg[PC_RUN_BIT];
	assign xfer_busy  = link_busy_reg | burst_reg;
	assign start_word = ~link_busy_reg & (tx_cnt_reg != '0) & ~stop_pend_reg &
		(periodic_mode ? burst_reg : 1'b1);
	assign rx_word    = place(rx_raw, cfg_reg[CFG_LEN_LSB +: 4], hold_rev_reg);

	// Transmit queue: push, pop at word start, flush when periodic stop completes
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tx_wr_reg  <= '0;
			tx_rd_reg  <= '0;
			tx_cnt_reg <= '0;
		end else if (stop_done) begin
			tx_wr_reg  <= '0;
			tx_rd_reg  <= '0;
			tx_cnt_reg <= '0; // [RL16]
		end else begin
			if (tx_push) begin
				tx_mem[tx_wr_reg] <= i_pwdata;
				tx_wr_reg <= next_ptr(tx_wr_reg);
			end
			if (start_word)
				tx_rd_reg <= next_ptr(tx_rd_reg);
			tx_cnt_reg <= tx_cnt_reg + CW'(tx_push) - CW'(start_word);
		end
	end

	// Word handed to the link; held until the done toggle returns
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			start_tgl_reg <= 1'b0;
			link_busy_reg <= 1'b0;
			tx_hold_reg   <= 32'h0000_0000;
			nbits_reg     <= FULL_BITS;
			hold_rev_reg  <= 1'b0;
		end else if (start_word) begin
			start_tgl_reg <= ~start_tgl_reg;
			link_busy_reg <= 1'b1;
			tx_hold_reg   <= tx_mem[tx_rd_reg];
			hold_rev_reg  <= cfg_reg[CFG_REV_BIT];
			nbits_reg     <= (cfg_reg[CFG_LEN_LSB +: 4] == 4'h0) ? FULL_BITS :
				{2'b00, cfg_reg[CFG_LEN_LSB +: 4]} + 6'h01;
		end else if (done_pulse) begin
			link_busy_reg <= 1'b0;
		end
	end

	// Receive queue; a full queue drops or overwrites the newest slot [RL14]
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rx_wr_reg  <= '0;
			rx_rd_reg  <= '0;
			rx_cnt_reg <= '0;
		end else begin
			if (rx_pop)
				rx_rd_reg <= next_ptr(rx_rd_reg);
			// Data of a transfer that ends during a stop request is lost
			if (done_pulse && !stop_pend_reg) begin
				if (rx_cnt_reg != DEPTH_C || rx_pop) begin
					rx_mem[rx_wr_reg] <= rx_word;
					rx_wr_reg  <= next_ptr(rx_wr_reg);
					rx_cnt_reg <= rx_cnt_reg + CW'(1) - CW'(rx_pop);
				end else begin
					if (!pcfg_reg[PC_DROP_BIT])
						rx_mem[(rx_wr_reg == '0) ? PW'(DEPTH - 1) : rx_wr_reg - PW'(1)] <=
							rx_word;
				end
			end else if (rx_pop) begin
				rx_cnt_reg <= rx_cnt_reg - CW'(1);
			end
		end
	end

	// Software-written registers
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cfg_reg <= CFG_RESET;
			cs_reg  <= CS_RESET;
			acs_reg <= CS_RESET;
			per_reg <= PER_RESET;
		end else if (wr_acc) begin
			if (i_paddr == OFS_CFG)
				cfg_reg <= i_pwdata[6:0];
			if (i_paddr == OFS_CS && SEL_PRESENT)
				cs_reg <= i_pwdata;
			if (i_paddr == OFS_ACS && SEL_PRESENT && AUTO_SEL_AVAIL) // [RL10]
				acs_reg <= i_pwdata;
			// Unimplemented high bits never stick, so a probe reads the width
			if (i_paddr == OFS_PER && PERIODIC_AVAIL) // [RL19] [RL22]
				per_reg <= i_pwdata & PER_MASK;
		end
	end

	// Final-word command and its sticky event; an event set wins over a clear
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			final_armed_reg <= 1'b0;
			char_seen_reg   <= 1'b0;
			final_event_reg <= 1'b0;
		end else begin
			if (final_set)
				final_armed_reg <= 1'b0; // [RL3]
			else if (wr_acc && i_paddr == OFS_CMD && i_pwdata[CMD_FINAL_BIT])
				final_armed_reg <= 1'b1;
			if (!final_armed_reg)
				char_seen_reg <= 1'b0;
			else if (done_pulse)
				char_seen_reg <= 1'b1;
			if (final_set)
				final_event_reg <= 1'b1;
			else if (wr_acc && i_paddr == OFS_STAT && i_pwdata[ST_FINAL_BIT])
				final_event_reg <= 1'b0;
		end
	end
	// Normal: on a finished character with empty queue; three-wire: when all is idle
	assign final_set = final_armed_reg & (cfg_reg[CFG_3W_BIT] ?
		(char_seen_reg & ~xfer_busy & ~done_pulse & (tx_cnt_reg == '0)) : // [RL2]
		(done_pulse & (tx_cnt_reg == '0))); // [RL1]

	// Periodic gating: strict, sequential drain and overflow skip
	assign occupancy  = {1'b0, rx_cnt_reg} + {1'b0, tx_cnt_reg};
	assign at_zero    = periodic_mode & ~stop_pend_reg & (pcnt_reg == 32'h0000_0000);
	assign skip_burst = pcfg_reg[PC_SKIP_BIT] & (occupancy > {1'b0, DEPTH_C}); // [RL13]
	assign gate_ok    = (pcfg_reg[PC_STRICT_BIT] | (rx_cnt_reg == '0)) & // [RL12]
		(~pcfg_reg[PC_SEQ_BIT] | drained_reg) & ~skip_burst; // [RL11]
	assign fire       = at_zero & ~xfer_busy & gate_ok & (tx_cnt_reg != '0);
	assign stop_done  = stop_pend_reg & ~link_busy_reg;

	// Period counter: wait out a running transfer before reloading [RL21]
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pcnt_reg <= PER_RESET;
		end else if (wr_acc && i_paddr == OFS_PCFG && i_pwdata[PC_RUN_BIT] && PERIODIC_AVAIL) begin
			pcnt_reg <= per_reg;
		end else if (periodic_mode && !stop_pend_reg) begin
			if (pcnt_reg != 32'h0000_0000)
				pcnt_reg <= pcnt_reg - 32'h0000_0001; // [RL20]
			else if (!xfer_busy)
				pcnt_reg <= per_reg;
		end
	end

	// Burst sends the whole queue; drain flag tracks software reading results
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			burst_reg   <= 1'b0;
			drained_reg <= 1'b1;
		end else begin
			if (stop_pend_reg || (burst_reg && tx_cnt_reg == '0 && !start_word))
				burst_reg <= 1'b0;
			else if (fire)
				burst_reg <= 1'b1; // [RL20]
			if (fire)
				drained_reg <= 1'b0;
			else if (!xfer_busy && rx_cnt_reg == '0)
				drained_reg <= 1'b1;
		end
	end

	// Periodic configuration: run, arm, stop request and trigger pulse
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pcfg_reg           <= 6'h00;
			stop_pend_reg      <= 1'b0;
			o_periodic_trigger <= 1'b0;
		end else begin
			o_periodic_trigger <= 1'b0;
			if (wr_acc && i_paddr == OFS_PCFG && PERIODIC_AVAIL) begin
				pcfg_reg[PC_SEQ_BIT]    <= i_pwdata[PC_SEQ_BIT];
				pcfg_reg[PC_STRICT_BIT] <= i_pwdata[PC_STRICT_BIT];
				pcfg_reg[PC_SKIP_BIT]   <= i_pwdata[PC_SKIP_BIT];
				pcfg_reg[PC_DROP_BIT]   <= i_pwdata[PC_DROP_BIT];
				pcfg_reg[PC_ARM_BIT]    <= i_pwdata[PC_ARM_BIT];
				if (i_pwdata[PC_RUN_BIT]) begin
					pcfg_reg[PC_RUN_BIT] <= 1'b1;
					o_periodic_trigger   <= 1'b1; // [RL15]
				end else if (pcfg_reg[PC_RUN_BIT]) begin
					stop_pend_reg <= 1'b1; // [RL16]
				end
			end else if (pcfg_reg[PC_ARM_BIT] && t2_reg) begin
				pcfg_reg[PC_ARM_BIT] <= 1'b0; // [RL18]
				pcfg_reg[PC_RUN_BIT] <= 1'b1;
			end else if (stop_done) begin
				// Run reads one until the ongoing word has finished
				pcfg_reg[PC_RUN_BIT] <= 1'b0;
				stop_pend_reg        <= 1'b0;
			end
		end
	end

	// Select outputs: register value, or automatic value while a transfer runs
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			o_select <= CS_RESET[SEL_COUNT-1:0];
		else if (!SEL_PRESENT)
			o_select <= CS_RESET[SEL_COUNT-1:0];
		else if (AUTO_SEL_AVAIL && cfg_reg[CFG_AUTO_SELECT_ON_BIT] && (xfer_busy || start_word))
			o_select <= acs_reg[SEL_COUNT-1:0]; // [RL9]
		else
			o_select <= cs_reg[SEL_COUNT-1:0]; // [RL8]
	end

	// Read data captured in the setup phase; receive window shows the head [RL6]
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			o_prdata <= 32'h0000_0000;
			unique case (i_paddr)
				OFS_CFG:  o_prdata <= {25'h0, cfg_reg};
				OFS_STAT: o_prdata <= {28'h0, xfer_busy, final_event_reg,
					rx_cnt_reg != '0, tx_cnt_reg != DEPTH_C};
				OFS_RX:   o_prdata <= (rx_cnt_reg != '0) ? rx_mem[rx_rd_reg] : 32'h0000_0000;
				OFS_CS:   o_prdata <= SEL_PRESENT ? cs_reg &
					32'((64'h1 << SEL_COUNT) - 64'h1) : 32'h0000_0000;
				OFS_ACS:  o_prdata <= (SEL_PRESENT && AUTO_SEL_AVAIL) ? acs_reg &
					32'((64'h1 << SEL_COUNT) - 64'h1) : 32'h0000_0000;
				OFS_PCFG: o_prdata <= PERIODIC_AVAIL ? {26'h0, pcfg_reg} : 32'h0000_0000;
				OFS_PER:  o_prdata <= per_reg;
				default:  o_prdata <= 32'h0000_0000; // Command and transmit read zero
			endcase
		end
	end
endmodule

//--- inc/spi_pq_pkg.sv
// Shared constants for the SPI queue and periodic transfer block
// Function
// RL1 - Final-word command raises final-char event after a character leaves with empty queue
// RL2 - In three-wire mode, event waits until the whole transfer has finished
// RL3 - Final-word command self-clears when its event sets; always reads zero
// RL4 - Transmit window write pushes a word only while room flag is set
// RL5 - Software places tx word at bit 0 or bit 31 by order bit
// RL6 - Receive window holds valid data whenever the has-word flag is set
// RL7 - Rx placement: full word for size 0, else MSB at 15 or LSB at 16
// RL8 - Select outputs follow the select register; no automatic changes there
// RL9 - Automatic select drives outputs during a transfer, then restores register value
// RL10 - Automatic select register exists only when the capability is present
// RL11 - Sequential mode waits for software to drain rx queue before next transfer
// RL12 - Strict period tries each zero; otherwise waits for empty rx queue
// RL13 - Skip-on-overflow omits periodic transfers that would overwrite rx data
// RL14 - Drop-on-overflow discards new rx data, else temporary slot is overwritten
// RL15 - Writing run starts countdown; trigger output pulses the cycle after
// RL16 - Clearing run finishes current transfer, loses its data, flushes tx queue
// RL17 - Software makes no other access until run reads back zero
// RL18 - Armed trigger input high starts periodic mode, clears arm, sets run
// RL19 - Periodic registers exist only when periodic capability is present
// RL20 - Counter decrements each cycle; at zero sends queue, reloads, continues
// RL21 - A running transfer at zero holds off new transfer and reload
// RL22 - Software probes period width by writing all ones and reading back
package spi_pq_pkg;
	localparam logic [7:0] OFS_CFG  = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_CMD  = 8'h08;
	localparam logic [7:0] OFS_TX   = 8'h0C;
	localparam logic [7:0] OFS_RX   = 8'h10;
	localparam logic [7:0] OFS_CS   = 8'h14;
	localparam logic [7:0] OFS_ACS  = 8'h18;
	localparam logic [7:0] OFS_PCFG = 8'h1C;
	localparam logic [7:0] OFS_PER  = 8'h20;
	// Own configuration register fields
	localparam int CFG_LEN_LSB  = 0;
	localparam int CFG_REV_BIT  = 4;
	localparam int CFG_3W_BIT   = 5;
	localparam int CFG_AUTO_SELECT_ON_BIT = 6;
	// Status register fields
	localparam int ST_ROOM_BIT  = 0;
	localparam int ST_WORD_BIT  = 1;
	localparam int ST_FINAL_BIT = 2;
	localparam int ST_BUSY_BIT  = 3;
	// Command and periodic configuration fields
	localparam int CMD_FINAL_BIT  = 22;
	localparam int PC_SEQ_BIT     = 5;
	localparam int PC_STRICT_BIT  = 4;
	localparam int PC_SKIP_BIT    = 3;
	localparam int PC_DROP_BIT    = 2;
	localparam int PC_RUN_BIT     = 1;
	localparam int PC_ARM_BIT     = 0;
	// Reset values and word geometry
	localparam logic [31:0] CS_RESET  = 32'hFFFF_FFFF;
	localparam logic [31:0] PER_RESET = 32'h0000_0000;
	localparam logic [6:0]  CFG_RESET = 7'h00;
	localparam logic [5:0]  FULL_BITS = 6'h20;
	localparam int          RX_HALF   = 16;
endpackage

//--- rtl/spi_link_shifter.sv
// Serial shifter running on the link clock; one word per start toggle
`timescale 1ns/1ps
module spi_link_shifter
	import spi_pq_pkg::*;
(
	input  wire logic        i_link_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_start_tgl,
	input  wire logic [31:0] i_tx_word,
	input  wire logic [5:0]  i_nbits,
	input  wire logic        i_msb_first,
	input  wire logic        i_miso,
	output logic             o_done_tgl,
	output logic [31:0]      o_rx_raw,
	output logic             o_mosi,
	output logic             o_frame
);
	logic        s1_reg, s2_reg, s3_reg;
	logic [31:0] sh_reg;
	logic [5:0]  cnt_reg;
	logic        start;

	// Start toggle crossing; word and size are held stable by the sender until done
	always_ff @(posedge i_link_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= i_start_tgl;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	assign start = s2_reg ^ s3_reg;

	// Shift out first bit by order, gather input at the opposite end
	always_ff @(posedge i_link_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sh_reg     <= 32'h0000_0000;
			cnt_reg    <= 6'h00;
			o_frame    <= 1'b0;
			o_mosi     <= 1'b0;
			o_rx_raw   <= 32'h0000_0000;
			o_done_tgl <= 1'b0;
		end else if (start) begin
			// First bit goes out with the frame so the peer never sees a stale level
			o_mosi   <= i_msb_first ? i_tx_word[31] : i_tx_word[0];
			sh_reg   <= i_msb_first ? {i_tx_word[30:0], 1'b0} : {1'b0, i_tx_word[31:1]};
			cnt_reg  <= i_nbits;
			o_frame  <= 1'b1;
			o_rx_raw <= 32'h0000_0000;
		end else if (o_frame) begin
			o_mosi <= i_msb_first ? sh_reg[31] : sh_reg[0];
			sh_reg <= i_msb_first ? {sh_reg[30:0], 1'b0} : {1'b0, sh_reg[31:1]};
			// MSB-first lands right-aligned, LSB-first lands top-aligned
			o_rx_raw <= i_msb_first ? {o_rx_raw[30:0], i_miso} : {i_miso, o_rx_raw[31:1]};
			cnt_reg  <= cnt_reg - 6'h01;
			if (cnt_reg == 6'h01) begin
				o_frame    <= 1'b0;
				o_done_tgl <= ~o_done_tgl;
			end
		end
	end
endmodule

//--- tb/spi_pq_props.sv
// Bus answer and trigger assertions for the SPI queue and periodic block
`timescale 1ns/1ps
module spi_pq_props
	import spi_pq_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [31:0] o_prdata,
	input  wire logic        o_pready,
	input  wire logic        o_pslverr,
	input  wire logic        o_periodic_trigger
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	logic acc;
	logic rds;
	// Access and read-setup phases of the register bus
	assign acc = i_psel && i_penable;
	assign rds = i_psel && !i_penable && !i_pwrite;

	AST_READY: assert property (acc |-> o_pready)
		else $error("access phase without ready");
	AST_ERR_UNMAPPED: assert property (acc && i_paddr > OFS_PER |-> o_pslverr)
		else $error("unmapped access without error");
	AST_ERR_MAPPED: assert property (acc && i_paddr <= OFS_PER && i_paddr[1:0] == 2'h0
		|-> !o_pslverr)
		else $error("mapped access flagged as error");
	AST_CMD_ZERO: assert property (rds && i_paddr == OFS_CMD |=> o_prdata == 32'h0000_0000)
		else $error("command register read not zero");
	AST_PCFG_RSVD: assert property (rds && i_paddr == OFS_PCFG |=> o_prdata[31:6] == 26'h0)
		else $error("periodic config reserved bits not zero");
	// Read data must not move while the master may still take it
	AST_PRDATA_HOLD: assert property (acc |=> $stable(o_prdata))
		else $error("read data changed after access");
	AST_TRIG_START: assert property (acc && i_pwrite && i_paddr == OFS_PCFG && i_pwdata[PC_RUN_BIT]
		|=> ##[0:1] o_periodic_trigger)
		else $error("no trigger pulse after run write");
	AST_TRIG_PULSE: assert property (o_periodic_trigger |=> !o_periodic_trigger)
		else $error("trigger pulse longer than one cycle");
endmodule

bind spi_queue_periodic spi_pq_props u_props (
	.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
	.o_pready(o_pready), .o_pslverr(o_pslverr), .o_periodic_trigger(o_periodic_trigger)
);

//--- tb/spi_slave_model.sv
// Behavioural SPI peripheral: answers all ones and records what it hears
`timescale 1ns/1ps
module spi_slave_model (
	input  wire logic        i_link_clk,
	input  wire logic        i_sel_n,
	input  wire logic        i_frame,
	input  wire logic        i_mosi,
	output logic             o_miso,
	output logic [31:0]      o_heard,
	output logic [5:0]       o_bits
);
	logic idle_bit = 1'b0;
	logic was_on = 1'b0;
	// Released line keeps changing so a stale level never passes as data
	always @(posedge i_link_clk) begin
		idle_bit <= ~idle_bit;
	end
	assign o_miso = (i_frame && !i_sel_n) ? 1'b1 : idle_bit;
	// Capture on the falling edge, when the launched bit has settled
	always @(negedge i_link_clk) begin
		was_on <= i_frame && !i_sel_n;
		if (i_frame && !i_sel_n) begin
			o_heard <= was_on ? {o_heard[30:0], i_mosi} : {31'h0, i_mosi};
			o_bits <= was_on ? o_bits + 6'h01 : 6'h01;
		end
	end
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the SPI queue and periodic transfer block
`timescale 1ns/1ps
module tb_top;
	import spi_pq_pkg::*;
	typedef struct {
		logic [31:0] cfg;
		logic [31:0] tx;
		logic [31:0] heard;
		logic [5:0]  bits;
		logic [31:0] rx;
	} row_t;
	logic        i_clk = 1'b0;
	logic        i_link_clk = 1'b0;
	logic        i_resetn = 1'b0;
	logic        i_psel = 1'b0;
	logic        i_penable = 1'b0;
	logic        i_pwrite = 1'b0;
	logic [7:0]  i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0000_0000;
	logic        i_periodic_trigger_pin = 1'b0;
	logic [31:0] o_prdata;
	logic        o_pready;
	logic        o_pslverr;
	logic        o_periodic_trigger;
	logic [0:0]  o_select;
	logic        miso;
	logic        mosi;
	logic        frame;
	logic [31:0] heard;
	logic [5:0]  nbits;
	logic [31:0] d;
	logic        err;
	int          n_fail = 0;
	int          checks = 0;
	// Word size, order, wire pattern and receive placement per case
	row_t rows [4] = '{
		'{32'h07, 32'h0000_0035, 32'h0000_00AC, 6'h08, 32'h0000_FF00},
		'{32'h17, 32'h3500_0000, 32'h0000_0035, 6'h08, 32'h00FF_0000},
		'{32'h10, 32'h1234_5678, 32'h1234_5678, 6'h20, 32'hFFFF_FFFF},
		'{32'h00, 32'h0000_0001, 32'h8000_0000, 6'h20, 32'hFFFF_FFFF}};

	always #12.5 i_clk = ~i_clk;
	always #16 i_link_clk = ~i_link_clk;

	spi_queue_periodic #(.PERIOD_BITS(12)) dut (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_link_clk(i_link_clk), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.i_periodic_trigger_pin(i_periodic_trigger_pin),
		.o_periodic_trigger(o_periodic_trigger), .o_select(o_select), .i_miso(miso),
		.o_mosi(mosi), .o_frame(frame));

	spi_slave_model peer (.i_link_clk(i_link_clk), .i_sel_n(o_select[0]), .i_frame(frame),
		.i_mosi(mosi), .o_miso(miso), .o_heard(heard), .o_bits(nbits));

	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One bus transfer; request held until the access edge, data taken there
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] w);
		@(negedge i_clk);
		i_psel = 1'b1;
		i_pwrite = wr;
		i_paddr = a;
		i_pwdata = w;
		@(negedge i_clk);
		i_penable = 1'b1;
		@(posedge i_clk);
		d = o_prdata;
		err = o_pslverr;
		@(negedge i_clk);
		i_psel = 1'b0;
		i_penable = 1'b0;
	endtask

	// Poll a status bit with a bounded number of reads
	task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
		int n;
		n = 0;
		apb(1'b0, a, 32'h0);
		while (d[b] !== v && n < 400) begin
			apb(1'b0, a, 32'h0);
			n++;
		end
		// A poll that runs out of reads counts as a mismatch
		check("poll_done", {31'h0, d[b]}, {31'h0, v});
	endtask

	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Bounded by 2 ms, far beyond the expected run length
	initial begin
		#2_000_000;
		n_fail++;
		wrap_up();
	end

	initial begin
		repeat (8) @(posedge i_clk);
		@(negedge i_clk);
		i_resetn = 1'b1;
		check("select_rst", {31'h0, o_select}, {31'h0, CS_RESET[0]});
		apb(1'b0, OFS_PER, 32'h0);
		check("per_rst", d, PER_RESET);
		apb(1'b0, 8'h40, 32'h0);
		check("unmapped_err", {31'h0, err}, 32'h1);
		apb(1'b1, OFS_PER, 32'hFFFF_FFFF);
		apb(1'b0, OFS_PER, 32'h0);
		check("per_probe", d, 32'h0000_0FFF);
		apb(1'b1, OFS_CS, 32'h0);
		repeat (2) @(negedge i_clk);
		check("select_follow", {31'h0, o_select}, 32'h0);
		// Ordinary transfers, one row each
		foreach (rows[i]) begin
			apb(1'b1, OFS_CFG, rows[i].cfg);
			apb(1'b1, OFS_TX, rows[i].tx);
			wait_bit(OFS_STAT, ST_WORD_BIT, 1'b1);
			apb(1'b0, OFS_RX, 32'h0);
			check("rx_word", d, rows[i].rx);
			check("heard", heard, rows[i].heard);
			check("bits", {26'h0, nbits}, {26'h0, rows[i].bits});
			apb(1'b0, OFS_STAT, 32'h0);
			check("rx_empty", {31'h0, d[ST_WORD_BIT]}, 32'h0);
		end
		// Final-word marker in normal and three-wire modes
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, OFS_CFG, (i == 0) ? 32'h07 : 32'h27);
			apb(1'b1, OFS_CMD, 32'h0040_0000);
			apb(1'b0, OFS_CMD, 32'h0);
			check("cmd_read", d, 32'h0);
			apb(1'b0, OFS_STAT, 32'h0);
			check("final_early", {31'h0, d[ST_FINAL_BIT]}, 32'h0);
			apb(1'b1, OFS_TX, 32'h0000_00FF);
			wait_bit(OFS_STAT, ST_FINAL_BIT, 1'b1);
			check("final_set", {31'h0, d[ST_FINAL_BIT]}, 32'h1);
			apb(1'b1, OFS_STAT, 32'h0000_0004);
			apb(1'b0, OFS_RX, 32'h0);
			apb(1'b0, OFS_STAT, 32'h0);
			check("final_clear", {31'h0, d[ST_FINAL_BIT]}, 32'h0);
		end
		// Automatic select: peer deselected by register, selected for the word
		apb(1'b1, OFS_CS, 32'h1);
		apb(1'b1, OFS_ACS, 32'h0);
		apb(1'b1, OFS_CFG, 32'h47);
		apb(1'b1, OFS_TX, 32'h0000_0035);
		wait_bit(OFS_STAT, ST_WORD_BIT, 1'b1);
		check("auto_heard", heard, 32'h0000_00AC);
		check("auto_restore", {31'h0, o_select}, 32'h1);
		apb(1'b0, OFS_RX, 32'h0);
		check("auto_rx", d, 32'h0000_FF00);
		apb(1'b1, OFS_ACS, 32'h1);
		apb(1'b0, OFS_ACS, 32'h0);
		check("acs_read", d, 32'h1);
		apb(1'b1, OFS_CFG, 32'h07);
		apb(1'b1, OFS_CS, 32'h0);
		// Stop with words still queued: they are dropped
		apb(1'b1, OFS_PER, 32'h0000_0FFF);
		apb(1'b1, OFS_PCFG, 32'h12);
		apb(1'b1, OFS_TX, 32'h1);
		apb(1'b1, OFS_TX, 32'h2);
		apb(1'b1, OFS_PCFG, 32'h10);
		wait_bit(OFS_PCFG, PC_RUN_BIT, 1'b0);
		check("stop_run", {31'h0, d[PC_RUN_BIT]}, 32'h0);
		repeat (100) @(negedge i_clk);
		apb(1'b0, OFS_STAT, 32'h0);
		check("stop_flush", {31'h0, d[ST_WORD_BIT]}, 32'h0);
		// Periodic burst sends the whole queue at the first zero
		apb(1'b1, OFS_PER, 32'h0000_0014);
		apb(1'b1, OFS_PCFG, 32'h12);
		apb(1'b1, OFS_TX, 32'h1);
		apb(1'b1, OFS_TX, 32'h2);
		wait_bit(OFS_STAT, ST_BUSY_BIT, 1'b1);
		wait_bit(OFS_STAT, ST_BUSY_BIT, 1'b0);
		for (int i = 0; i < 2; i++) begin
			apb(1'b0, OFS_RX, 32'h0);
			check("burst_rx", d, 32'h0000_FF00);
		end
		apb(1'b1, OFS_PCFG, 32'h10);
		wait_bit(OFS_PCFG, PC_RUN_BIT, 1'b0);
		// Armed trigger pin starts periodic mode
		apb(1'b1, OFS_PCFG, 32'h11);
		i_periodic_trigger_pin = 1'b1;
		wait_bit(OFS_PCFG, PC_RUN_BIT, 1'b1);
		check("arm_start", {30'h0, d[1:0]}, 32'h2);
		i_periodic_trigger_pin = 1'b0;
		apb(1'b1, OFS_PCFG, 32'h10);
		wait_bit(OFS_PCFG, PC_RUN_BIT, 1'b0);
		check("arm_stop", {31'h0, d[PC_RUN_BIT]}, 32'h0);
		wrap_up();
	end
endmodule
